// File: core/srre_exec.sv
// Purpose: Executes subroutine return and rotate-left-through-carry
// Assumes: Each clk is one quarter phase; instrWord sampled in Q1
// Notes:   Register port: ctrl at 0x0, state readback at 0x4
//
// Function
// [RULE1] Return is word 0000_0000_0001_001s, s selects shadow restore
// [RULE2] Return pops the call stack and loads its top into pc
// [RULE3] With s=1, working, flag and bank registers take shadow copies
// [RULE4] With s=0, working, flag and bank registers are untouched
// [RULE5] Return leaves the pc latch registers alone; only pc changes
// [RULE6] Return alters no flags except by a whole-register restore
// [RULE7] Return takes one word, two cycles; pop in Q4, second cycle idle
// [RULE8] Rotate is 001101 then d, a and an 8-bit file address
// [RULE9] Rotate left through carry: bit 7 to carry, carry to bit 0
// [RULE10] d=0 writes working register, d=1 writes the file register
// [RULE11] a=0 uses the access bank, a=1 uses the bank select register
// [RULE12] a=0, extended set on, address up to 95: indexed literal offset
// [RULE13] Rotate updates carry, negative and zero, no other flags
// [RULE14] Rotate is one cycle: read Q2, process Q3, write Q4
// [RULE15] Negative is result bit 7, zero set when result is zero
`include "srre_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module srre_exec #(
	parameter int unsigned ACCESS_LIMIT = `SRRE_ACCESS_LIM
) (
	input  wire logic                         clk,
	input  wire logic                         rst_b,
	input  wire logic                         instrValid,
	input  wire logic [15:0]                  instrWord,
	input  wire logic [`SRRE_PC_W-1:0]        stackTopValue,
	input  wire srre_pkg::srre_shadow_t       callShadow,
	input  wire logic [`SRRE_ADDR_W-1:0]      indexBase,
	input  wire logic [7:0]                   memRdData,
	input  wire logic [3:0]                   regAddr,
	input  wire logic [31:0]                  regWrData,
	input  wire logic                         regWr,
	input  wire logic                         regRd,
	output logic [31:0]                       regRdData,
	output srre_pkg::srre_mem_req_t           memReq,
	output logic                              stackPop,
	output logic [`SRRE_PC_W-1:0]             pcOut,
	output logic [7:0]                        workingRegister,
	output logic [7:0]                        flagRegister,
	output logic [7:0]                        bankSelectRegister,
	output logic [1:0]                        quarterPhase,
	output logic                              busy
);

	// Refuse an access split that an 8-bit address cannot hold
	if (ACCESS_LIMIT > 255) begin : g_chk
		$error("ACCESS_LIMIT above 255");
	end

	srre_pkg::srre_state_t sQ;
	srre_pkg::srre_state_t sD;

	// Return decode
	function automatic logic isReturn(input logic [15:0] w);
		isReturn = (w & `SRRE_RET_MASK) == `SRRE_RET_CODE; // RULE1
	endfunction : isReturn

	// Rotate decode
	function automatic logic isRotate(input logic [15:0] w);
		isRotate = w[15:10] == `SRRE_ROT_CODE; // RULE8
	endfunction : isRotate

	// Data address of a file operand
	function automatic logic [`SRRE_ADDR_W-1:0] fileAddr(
		input logic [7:0]              f,
		input logic                    a,
		input logic                    ext,
		input logic [7:0]              bank,
		input logic [`SRRE_ADDR_W-1:0] base
	);
		logic low;
		low = f <= 8'(ACCESS_LIMIT);
		if (a)
			fileAddr = {bank, f}; // RULE11
		else if (ext && low)
			fileAddr = base + {8'h00, f}; // RULE12
		else if (low)
			fileAddr = {`SRRE_LOW_PAGE, f}; // RULE11
		else
			fileAddr = {`SRRE_SFR_PAGE, f};
	endfunction : fileAddr

	// Next state
	always_comb
	begin
		logic [7:0] res;
		res = {sQ.result};
		sD = sQ;
		sD.phase = sQ.phase + 2'h1;
		sD.mem.rd = 1'b0;
		sD.mem.wr = 1'b0;
		sD.stackPop = 1'b0;
		sD.regRdata = `SRRE_RST_WORD;
		case (sQ.phase)
			`SRRE_Q1:
			begin
				// Decode; a return's second cycle takes nothing
				if (sQ.cyc == srre_pkg::SRRE_CYC_EXEC && instrValid)
				begin
					sD.ir = instrWord;
					if (isReturn(instrWord))
					begin
						sD.op = srre_pkg::SRRE_OP_RET;
						sD.busy = 1'b1;
					end
					else if (isRotate(instrWord))
					begin
						sD.op = srre_pkg::SRRE_OP_ROT;
						sD.busy = 1'b1;
						sD.mem.rd = 1'b1; // RULE14
						sD.mem.addr = fileAddr(instrWord[7:0], instrWord[`SRRE_BIT_A],
							sQ.extEn, sQ.bank, indexBase);
					end
					else
						sD.op = srre_pkg::SRRE_OP_NONE;
				end
			end
			`SRRE_Q2:
			begin
				// Memory read in flight for a rotate
			end
			`SRRE_Q3:
			begin
				// Rotate through carry on the fetched byte
				if (sQ.op == srre_pkg::SRRE_OP_ROT)
				begin
					sD.result = {memRdData[6:0], sQ.flags[`SRRE_FLAG_C]}; // RULE9
					sD.carryNew = memRdData[7]; // RULE9
				end
			end
			`SRRE_Q4:
			begin
				if (sQ.op == srre_pkg::SRRE_OP_ROT)
				begin
					// Write destination and the three flags only
					if (sQ.ir[`SRRE_BIT_D])
					begin
						sD.mem.wr = 1'b1; // RULE10
						sD.mem.wdata = res;
					end
					else
						sD.work = res; // RULE10
					sD.flags[`SRRE_FLAG_C] = sQ.carryNew; // RULE13
					sD.flags[`SRRE_FLAG_N] = res[7]; // RULE15
					sD.flags[`SRRE_FLAG_Z] = res == `SRRE_RST_BYTE; // RULE15
					sD.busy = 1'b0; // RULE14
				end
				else if (sQ.op == srre_pkg::SRRE_OP_RET)
				begin
					// Pop into pc only; latches are not in this path
					sD.pc = stackTopValue; // RULE2 RULE5
					sD.stackPop = 1'b1; // RULE2
					sD.cyc = srre_pkg::SRRE_CYC_RET2; // RULE7
					if (sQ.ir[`SRRE_BIT_S])
					begin
						sD.work = callShadow.work; // RULE3
						sD.flags = callShadow.flags; // RULE3 RULE6
						sD.bank = callShadow.bank; // RULE3
					end
				end
				else if (sQ.cyc == srre_pkg::SRRE_CYC_RET2)
				begin
					sD.cyc = srre_pkg::SRRE_CYC_EXEC; // RULE7
					sD.busy = 1'b0;
				end
				sD.op = srre_pkg::SRRE_OP_NONE;
			end
			default:
			begin
				sD.phase = `SRRE_Q1;
			end
		endcase
		// Register port: ctrl write, read data one cycle later
		if (regWr && regAddr == `SRRE_REG_CTRL)
			sD.extEn = regWrData[`SRRE_CTRL_EXT];
		if (regRd)
		begin
			case (regAddr)
				`SRRE_REG_CTRL:  sD.regRdata = {31'h00000000, sQ.extEn};
				`SRRE_REG_STATE: sD.regRdata = {sQ.busy, 7'h00, sQ.bank, sQ.flags, sQ.work};
				default:         sD.regRdata = `SRRE_RST_WORD;
			endcase
		end
	end

	// State register
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sQ <= '0;
		end
		else
			sQ <= sD;
	end

	// Outputs straight from the state flops
	assign regRdData          = sQ.regRdata;
	assign memReq             = sQ.mem;
	assign stackPop           = sQ.stackPop;
	assign pcOut              = sQ.pc;
	assign workingRegister    = sQ.work;
	assign flagRegister       = sQ.flags;
	assign bankSelectRegister = sQ.bank;
	assign quarterPhase       = sQ.phase;
	assign busy               = sQ.busy;

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	logic retQ4;
	logic rotQ1;
	assign retQ4 = sQ.phase == `SRRE_Q4 && sQ.op == srre_pkg::SRRE_OP_RET;
	assign rotQ1 = sQ.phase == `SRRE_Q1 && sQ.cyc == srre_pkg::SRRE_CYC_EXEC
		&& instrValid && isRotate(instrWord);

	property p_ret_decode;
		sQ.phase == `SRRE_Q1 && sQ.cyc == srre_pkg::SRRE_CYC_EXEC && instrValid
			&& isReturn(instrWord) |=> ##2 retQ4;
	endproperty
	a_ret_decode: assert property (p_ret_decode) else $error("return not decoded"); // RULE1

	property p_ret_pop;
		retQ4 |=> stackPop && pcOut == $past(stackTopValue);
	endproperty
	a_ret_pop: assert property (p_ret_pop) else $error("pc not popped"); // RULE2

	property p_ret_restore;
		retQ4 && sQ.ir[`SRRE_BIT_S] |=> workingRegister == $past(callShadow.work)
			&& flagRegister == $past(callShadow.flags)
			&& bankSelectRegister == $past(callShadow.bank);
	endproperty
	a_ret_restore: assert property (p_ret_restore) else $error("shadow not restored"); // RULE3

	property p_ret_keep;
		retQ4 && !sQ.ir[`SRRE_BIT_S] |=> $stable(workingRegister) && $stable(flagRegister)
			&& $stable(bankSelectRegister);
	endproperty
	a_ret_keep: assert property (p_ret_keep) else $error("return changed registers"); // RULE4

	property p_ret_len;
		retQ4 |=> (sQ.cyc == srre_pkg::SRRE_CYC_RET2 && !memReq.rd)[*4]
			##1 sQ.cyc == srre_pkg::SRRE_CYC_EXEC;
	endproperty
	a_ret_len: assert property (p_ret_len) else $error("return length wrong"); // RULE7

	property p_rot_bank;
		rotQ1 && instrWord[`SRRE_BIT_A] |=> memReq.rd
			&& memReq.addr == {$past(bankSelectRegister), $past(instrWord[7:0])};
	endproperty
	a_rot_bank: assert property (p_rot_bank) else $error("banked address wrong"); // RULE11

	property p_rot_index;
		rotQ1 && !instrWord[`SRRE_BIT_A] && sQ.extEn && instrWord[7:0] <= 8'(ACCESS_LIMIT)
			|=> memReq.addr == $past(indexBase) + {8'h00, $past(instrWord[7:0])};
	endproperty
	a_rot_index: assert property (p_rot_index) else $error("indexed address wrong"); // RULE12

	property p_rot_work;
		sQ.phase == `SRRE_Q3 && sQ.op == srre_pkg::SRRE_OP_ROT && !sQ.ir[`SRRE_BIT_D]
			|-> ##2 workingRegister == {$past(memRdData[6:0], 2),
				$past(flagRegister[`SRRE_FLAG_C], 2)}
			&& flagRegister[`SRRE_FLAG_C] == $past(memRdData[7], 2) && !memReq.wr;
	endproperty
	a_rot_work: assert property (p_rot_work) else $error("rotate to W wrong"); // RULE9

	property p_rot_file;
		sQ.phase == `SRRE_Q4 && sQ.op == srre_pkg::SRRE_OP_ROT && sQ.ir[`SRRE_BIT_D]
			|=> memReq.wr && $stable(workingRegister)
			&& flagRegister[`SRRE_FLAG_N] == memReq.wdata[7]
			&& flagRegister[`SRRE_FLAG_Z] == (memReq.wdata == `SRRE_RST_BYTE);
	endproperty
	a_rot_file: assert property (p_rot_file) else $error("rotate to file wrong"); // RULE10

	property p_rot_flags;
		sQ.phase == `SRRE_Q4 && sQ.op == srre_pkg::SRRE_OP_ROT
			|=> (flagRegister & ~`SRRE_ROT_FLAGS) == ($past(flagRegister) & ~`SRRE_ROT_FLAGS);
	endproperty
	a_rot_flags: assert property (p_rot_flags) else $error("other flags changed"); // RULE13

	property p_rot_one;
		rotQ1 |=> memReq.rd ##3 !busy && !stackPop;
	endproperty
	a_rot_one: assert property (p_rot_one) else $error("rotate not one cycle"); // RULE14

	cover property (retQ4 && sQ.ir[`SRRE_BIT_S]);
	cover property (retQ4 && !sQ.ir[`SRRE_BIT_S]);
	cover property (rotQ1 && !instrWord[`SRRE_BIT_D]);
	cover property (rotQ1 && instrWord[`SRRE_BIT_D] && !instrWord[`SRRE_BIT_A]);

endmodule : srre_exec

`default_nettype wire

// File: core/srre_cfg.svh
// Purpose: Constants for the return and rotate execution unit
// Assumes: Data addresses are 16 bits, program counter is 21 bits
// Notes:   Definitions only; included by bare name
`ifndef SRRE_CFG_SVH
`define SRRE_CFG_SVH

`define SRRE_PC_W        21
`define SRRE_ADDR_W      16
`define SRRE_Q1          2'h0
`define SRRE_Q2          2'h1
`define SRRE_Q3          2'h2
`define SRRE_Q4          2'h3
`define SRRE_RET_MASK    16'hFFFE
`define SRRE_RET_CODE    16'h0012
`define SRRE_ROT_CODE    6'h0D
`define SRRE_BIT_S       0
`define SRRE_BIT_A       8
`define SRRE_BIT_D       9
`define SRRE_ACCESS_LIM  95
`define SRRE_LOW_PAGE    8'h00
`define SRRE_SFR_PAGE    8'hFF
`define SRRE_FLAG_C      0
`define SRRE_FLAG_Z      2
`define SRRE_FLAG_N      4
`define SRRE_ROT_FLAGS   8'h15
`define SRRE_REG_CTRL    4'h0
`define SRRE_REG_STATE   4'h4
`define SRRE_CTRL_EXT    0
`define SRRE_RST_BYTE    8'h00
`define SRRE_RST_PC      21'h000000
`define SRRE_RST_WORD    32'h00000000

`endif

// File: core/srre_pkg.sv
// Purpose: Types for the return and rotate execution unit
// Assumes: srre_cfg.svh supplies widths
// Notes:   Shared by the core and the bench
`include "srre_cfg.svh"

package srre_pkg;

	// Instruction cycle: normal or the idle second cycle of a return
	typedef enum logic [0:0] {
		SRRE_CYC_EXEC = 1'b0,
		SRRE_CYC_RET2 = 1'b1
	} srre_cyc_t;

	// Instruction in flight
	typedef enum logic [1:0] {
		SRRE_OP_NONE = 2'b00,
		SRRE_OP_RET  = 2'b01,
		SRRE_OP_ROT  = 2'b10
	} srre_op_t;

	// Call shadow set presented by the call logic
	typedef struct packed {
		logic [7:0] work;
		logic [7:0] flags;
		logic [7:0] bank;
	} srre_shadow_t;

	// Data memory request, one-cycle strobes
	typedef struct packed {
		logic [`SRRE_ADDR_W-1:0] addr;
		logic                    rd;
		logic                    wr;
		logic [7:0]              wdata;
	} srre_mem_req_t;

	// Whole state of the unit
	typedef struct packed {
		logic [1:0]           phase;
		srre_cyc_t            cyc;
		srre_op_t             op;
		logic [15:0]          ir;
		logic [7:0]           result;
		logic                 carryNew;
		logic [`SRRE_PC_W-1:0] pc;
		logic [7:0]           work;
		logic [7:0]           flags;
		logic [7:0]           bank;
		srre_mem_req_t        mem;
		logic                 stackPop;
		logic                 extEn;
		logic                 busy;
		logic [31:0]          regRdata;
	} srre_state_t;

endpackage : srre_pkg

// File: test/srre_exec_tb.sv
// Purpose: Self-checking bench for the return and rotate unit
// Assumes: Bench drives every port; 250 MHz clk, one clk per quarter
// Notes:   Expected W, flags and bank are tracked here from reset; pc is checked against each return's stack top
`include "srre_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module srre_exec_tb;
	logic                    clk = 1'b0;
	logic                    rst_b = 1'b0;
	logic                    instrValid = 1'b0;
	logic [15:0]             instrWord = 16'h0000;
	logic [20:0]             stackTopValue = 21'h000000;
	srre_pkg::srre_shadow_t  callShadow = '0;
	logic [15:0]             indexBase = 16'h1200;
	logic [7:0]              memRdData = 8'h00;
	logic [3:0]              regAddr = 4'h0;
	logic [31:0]             regWrData = 32'h00000000;
	logic                    regWr = 1'b0;
	logic                    regRd = 1'b0;
	logic [31:0]             regRdData;
	srre_pkg::srre_mem_req_t memReq;
	logic                    stackPop;
	logic [20:0]             pcOut;
	logic [7:0]              workingRegister;
	logic [7:0]              flagRegister;
	logic [7:0]              bankSelectRegister;
	logic [1:0]              quarterPhase;
	logic                    busy;
	int                      n_mismatch = 0;
	int                      cmp_count = 0;
	int                      cycN = 0;
	logic [7:0]              expW = 8'h00;
	logic [7:0]              expF = 8'h00;
	logic [7:0]              expB = 8'h00;

	srre_exec srre_exec_inst (.clk(clk), .rst_b(rst_b), .instrValid(instrValid),
		.instrWord(instrWord), .stackTopValue(stackTopValue), .callShadow(callShadow),
		.indexBase(indexBase), .memRdData(memRdData), .regAddr(regAddr),
		.regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
		.memReq(memReq), .stackPop(stackPop), .pcOut(pcOut),
		.workingRegister(workingRegister), .flagRegister(flagRegister),
		.bankSelectRegister(bankSelectRegister), .quarterPhase(quarterPhase), .busy(busy));

	// Quarter-phase clock
	always #2 clk = ~clk;

	// Hang guard
	always @(posedge clk)
	begin
		cycN++;
		if (cycN == 3000)
		begin
			n_mismatch++;
			report_and_stop();
		end
	end

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge clk);
		regWr <= 1'b0;
	endtask : reg_wr

	task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRd <= 1'b0;
		#1 d = regRdData;
	endtask : reg_rd

	// Compares outputs and the state readback with the tracked values
	task automatic chk_state();
		logic [31:0] r;
		chk("W", {24'h0, expW}, {24'h0, workingRegister});
		chk("flags", {24'h0, expF}, {24'h0, flagRegister});
		chk("bank", {24'h0, expB}, {24'h0, bankSelectRegister});
		reg_rd(4'h4, r);
		chk("state", {8'h00, expB, expF, expW}, r);
	endtask : chk_state

	// Offers a word in the next Q1 cycle; returns after the edge that takes it
	task automatic issue(input logic [15:0] w);
		int n;
		n = 0;
		do
		begin
			@(posedge clk);
			#1 n++;
		end
		while (quarterPhase !== 2'h3 && n < 20);
		@(posedge clk);
		instrValid <= 1'b1;
		instrWord <= w;
		@(posedge clk);
		instrValid <= 1'b0;
	endtask : issue

	task automatic rot(input logic d, input logic a, input logic [7:0] f,
		input logic [7:0] data, input logic [15:0] addr);
		logic [7:0] res;
		res = {data[6:0], expF[0]};
		@(posedge clk);
		memRdData <= data;
		issue({6'h0D, d, a, f});
		#1 chk("rd", 32'h1, {31'h0, memReq.rd});
		chk("addr", {16'h0, addr}, {16'h0, memReq.addr});
		chk("busy", 32'h1, {31'h0, busy});
		repeat (3) @(posedge clk);
		#1 chk("wr", {31'h0, d}, {31'h0, memReq.wr});
		if (d)
			chk("wdata", {24'h0, res}, {24'h0, memReq.wdata});
		else
			expW = res;
		expF = (expF & 8'hEA) | {3'h0, res[7], 1'b0, res == 8'h00, 1'b0, data[7]};
		chk_state();
		$display("rotate test done");
	endtask : rot

	task automatic ret(input logic s, input logic [20:0] top, input logic [23:0] sh);
		@(posedge clk);
		stackTopValue <= top;
		callShadow <= sh;
		issue({15'h0009, s});
		repeat (3) @(posedge clk);
		instrValid <= 1'b1;
		instrWord <= 16'h3420;
		#1 chk("pc", {11'h0, top}, {11'h0, pcOut});
		chk("pop", 32'h1, {31'h0, stackPop});
		chk("ret busy", 32'h1, {31'h0, busy});
		if (s)
		begin
			expW = sh[23:16];
			expF = sh[15:8];
			expB = sh[7:0];
		end
		chk("W", {24'h0, expW}, {24'h0, workingRegister});
		chk("flags", {24'h0, expF}, {24'h0, flagRegister});
		chk("bank", {24'h0, expB}, {24'h0, bankSelectRegister});
		@(posedge clk);
		instrValid <= 1'b0;
		#1 chk("refused rd", 32'h0, {31'h0, memReq.rd});
		chk("pop once", 32'h0, {31'h0, stackPop});
		$display("return test done");
	endtask : ret

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : report_and_stop

	// Main sequence
	initial
	begin
		logic [31:0] r;
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		#1 chk("phase", 32'h0, {30'h0, quarterPhase});
		reg_rd(4'h0, r);
		chk("ctrl", 32'h0, r);
		reg_wr(4'h8, 32'hFFFFFFFF);
		reg_rd(4'h8, r);
		chk("unmapped", 32'h0, r);
		$display("register test done");
		rot(1'b0, 1'b0, 8'h20, 8'hE6, 16'h0020);
		ret(1'b1, 21'h1ABCDE, 24'h5A_0105);
		rot(1'b1, 1'b1, 8'h80, 8'h80, 16'h0580);
		ret(1'b0, 21'h0F0F0F, 24'hA5_FFFF);
		reg_wr(4'h0, 32'h00000001);
		reg_rd(4'h0, r);
		chk("ctrl", 32'h1, r);
		@(posedge clk);
		#1 chk("rd zero", 32'h0, regRdData);
		rot(1'b1, 1'b0, 8'h60, 8'h80, 16'hFF60);
		rot(1'b0, 1'b0, 8'h5F, 8'h01, 16'h125F);
		rot(1'b1, 1'b1, 8'h5F, 8'h00, 16'h055F);
		report_and_stop();
	end
endmodule : srre_exec_tb

`default_nettype wire
